// ==== dcfs_pkg.sv ====
// Constants for the FIFO flag logic: register map, fields, resets, timing.
// Assumes a single system clock of 125 MHz.
`default_nettype none
package dcfs_pkg;
  localparam int DATA_W = 18;
  localparam int DEPTH_SMALL = 512;
  localparam int DEPTH_LARGE = 1024;
  localparam int CLK_MHZ = 125;
  // Least skews, in ns, then in whole cycles (rounded up)
  localparam int WRITE_AFTER_READ_SKEW_NS = 24;
  localparam int READ_AFTER_WRITE_SKEW_NS = 24;
  localparam int WRITE_AFTER_READ_SKEW_CYC = (WRITE_AFTER_READ_SKEW_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_AFTER_WRITE_SKEW_CYC = (READ_AFTER_WRITE_SKEW_NS * CLK_MHZ + 999) / 1000;
  // Register offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_AE_OFFSET = 8'h04;
  localparam logic [7:0] OFS_AF_OFFSET = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  // Config fields
  localparam int CFG_AE_SYNC = 0;
  localparam int CFG_HF_LO = 1;
  localparam int CFG_HF_HI = 2;
  localparam int CFG_AF_SYNC = 3;
  localparam int CFG_W = 4;
  localparam logic [3:0] CONFIG_RESET = 4'h0;
  // Half-full clocking codes
  localparam logic [1:0] HF_ASYNC = 2'b00;
  localparam logic [1:0] HF_READ_SIDE = 2'b01;
  // Status fields
  localparam int ST_COUNT_LO = 0;
  localparam int ST_FLAGS_LO = 16;
  // Interrupt events
  localparam int IRQ_OVERRUN = 0;
  localparam int IRQ_UNDERRUN = 1;
  localparam int IRQ_W = 2;
endpackage : dcfs_pkg
`default_nettype wire

// ==== dcfs_mem_if.sv ====
// Port bundle between the flag logic and its storage array.
// Assumes one clock shared by both ends.
`default_nettype none
interface dcfs_mem_if #(
  parameter int AW = 9,
  parameter int W = 18
);
  logic we;
  logic [AW-1:0] waddr;
  logic [W-1:0] wdata;
  logic re;
  logic [AW-1:0] raddr;
  logic [W-1:0] rdata;
  modport ctrl (output we, waddr, wdata, re, raddr, input rdata);
  modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface : dcfs_mem_if
`default_nettype wire

// ==== dcfs_mem.sv ====
// Storage array with registered read data.
// Assumes the controller never reads and writes beyond the depth.
`default_nettype none
module dcfs_mem #(
  parameter int AW = 9,
  parameter int W = 18
) (
  // Clock
  input wire logic clk_sys,
  // Array port
  dcfs_mem_if.mem m
);
  logic [W-1:0] store [2**AW];

  // Write side
  always_ff @(posedge clk_sys) begin
    if (m.we) begin
      store[m.waddr] <= m.wdata;
    end
  end

  // Read side
  always_ff @(posedge clk_sys) begin
    if (m.re) begin
      m.rdata <= store[m.raddr];
    end
  end
endmodule : dcfs_mem
`default_nettype wire

// ==== dcfs_fifo_flags.sv ====
// FIFO with full, empty, almost and half-full flags clocked per port.
// Assumes port clocks arrive as inputs synchronous to clk_sys.
// Notes on behaviour
// - Array holds 18-bit words, 512 or 1024 deep
// - Full flag moves only at write edges
// - Empty flag moves only at read edges
// - Offset registers loadable; defaults otherwise kept
// - Offsets reset to depth/8 minus one
// - Almost flags: within offset of full/empty
// - Write edge after read skew sees read
// - Read edge after write skew sees write
// - Writes refused while full flag asserted
// - Reads refused while empty flag asserted
// - Middle flags unsynchronised by default
// - Half-full clocking chosen by two-bit code
// - Almost flags optionally synchronised to own port
//
// The plain strobed port and the address map were chosen for this implementation.
`default_nettype none
module dcfs_fifo_flags #(
  parameter int DEPTH = dcfs_pkg::DEPTH_SMALL
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Write port
  input wire logic wr_clk,
  input wire logic wr_en,
  input wire logic [dcfs_pkg::DATA_W-1:0] wr_data,
  // Read port
  input wire logic rd_clk,
  input wire logic rd_en,
  output logic [dcfs_pkg::DATA_W-1:0] rd_data,
  // Flags, active low
  output logic full_flag_n,
  output logic empty_flag_n,
  output logic almost_full_flag_n,
  output logic almost_empty_flag_n,
  output logic half_full_flag_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Interrupt
  output logic irq
);
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);
  localparam logic [PW-1:0] HALF_P = PW'(DEPTH / 2);
  localparam logic [AW-1:0] OFFSET_RESET = AW'(DEPTH / 8 - 1);

  // Supported depths only
  if (!(DEPTH == dcfs_pkg::DEPTH_SMALL || DEPTH == dcfs_pkg::DEPTH_LARGE)) begin : g_chk
    $error("DEPTH must be 512 or 1024");
  end

  logic wr_clk_d, rd_clk_d, wr_edge, rd_edge, wr_acc, rd_acc;
  logic [PW-1:0] wr_ptr_reg, rd_ptr_reg, cnt_reg, cnt_next;
  logic [PW-1:0] rd_ptr_s1, rd_ptr_s2, wr_ptr_s1, wr_ptr_s2;
  logic [PW-1:0] wcount_next, rcount_next;
  logic [dcfs_pkg::CFG_W-1:0] config_reg;
  logic [AW-1:0] ae_off_reg, af_off_reg;
  logic [dcfs_pkg::IRQ_W-1:0] irq_stat_reg, irq_mask_reg, irq_set;
  logic [1:0] hf_mode;

  dcfs_mem_if #(.AW(AW), .W(dcfs_pkg::DATA_W)) mif ();

  dcfs_mem #(.AW(AW), .W(dcfs_pkg::DATA_W)) u_mem (
    .clk_sys(clk_sys),
    .m(mif.mem)
  );

  // Port clock edge detection
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_clk_d <= 1'b0;
      rd_clk_d <= 1'b0;
    end else begin
      wr_clk_d <= wr_clk;
      rd_clk_d <= rd_clk;
    end
  end
  assign wr_edge = wr_clk & ~wr_clk_d;
  assign rd_edge = rd_clk & ~rd_clk_d;

  // Accept only when flag and true count allow
  assign wr_acc = wr_edge & wr_en & full_flag_n & (cnt_reg != DEPTH_P);
  assign rd_acc = rd_edge & rd_en & empty_flag_n & (cnt_reg != '0);

  // Storage access
  assign mif.we = wr_acc;
  assign mif.waddr = wr_ptr_reg[AW-1:0];
  assign mif.wdata = wr_data;
  assign mif.re = rd_acc;
  assign mif.raddr = rd_ptr_reg[AW-1:0];
  assign rd_data = mif.rdata;

  // Pointers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + PW'(wr_acc);
      rd_ptr_reg <= rd_ptr_reg + PW'(rd_acc);
      cnt_reg <= cnt_next;
    end
  end
  assign cnt_next = cnt_reg + PW'(wr_acc) - PW'(rd_acc);

  // Opposite pointers through two stages
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_ptr_s1 <= '0;
      rd_ptr_s2 <= '0;
      wr_ptr_s1 <= '0;
      wr_ptr_s2 <= '0;
    end else begin
      rd_ptr_s1 <= rd_ptr_reg;
      rd_ptr_s2 <= rd_ptr_s1;
      wr_ptr_s1 <= wr_ptr_reg;
      wr_ptr_s2 <= wr_ptr_s1;
    end
  end
  assign wcount_next = wr_ptr_reg + PW'(wr_acc) - rd_ptr_s2;
  assign rcount_next = wr_ptr_s2 - rd_ptr_reg - PW'(rd_acc);

  // Full and empty flags
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      full_flag_n <= 1'b1;
      empty_flag_n <= 1'b0;
    end else begin
      if (wr_edge) begin
        full_flag_n <= (wcount_next != DEPTH_P);
      end
      if (rd_edge) begin
        empty_flag_n <= (rcount_next != '0);
      end
    end
  end

  // Middle flags
  assign hf_mode = config_reg[dcfs_pkg::CFG_HF_HI:dcfs_pkg::CFG_HF_LO];
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      almost_full_flag_n <= 1'b1;
      almost_empty_flag_n <= 1'b0;
      half_full_flag_n <= 1'b1;
    end else begin
      if (!config_reg[dcfs_pkg::CFG_AF_SYNC]) begin
        almost_full_flag_n <= !((DEPTH_P - cnt_next) <= PW'(af_off_reg));
      end else if (wr_edge) begin
        almost_full_flag_n <= !((DEPTH_P - wcount_next) <= PW'(af_off_reg));
      end
      if (!config_reg[dcfs_pkg::CFG_AE_SYNC]) begin
        almost_empty_flag_n <= !(cnt_next <= PW'(ae_off_reg));
      end else if (rd_edge) begin
        almost_empty_flag_n <= !(rcount_next <= PW'(ae_off_reg));
      end
      if (hf_mode == dcfs_pkg::HF_ASYNC) begin
        half_full_flag_n <= !(cnt_next > HALF_P);
      end else if (hf_mode == dcfs_pkg::HF_READ_SIDE) begin
        if (rd_edge) begin
          half_full_flag_n <= !(rcount_next > HALF_P);
        end
      end else if (wr_edge) begin
        half_full_flag_n <= !(wcount_next > HALF_P);
      end
    end
  end

  // Software registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      config_reg <= dcfs_pkg::CONFIG_RESET;
      ae_off_reg <= OFFSET_RESET;
      af_off_reg <= OFFSET_RESET;
      irq_mask_reg <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        dcfs_pkg::OFS_CONFIG: config_reg <= reg_wdata[dcfs_pkg::CFG_W-1:0];
        dcfs_pkg::OFS_AE_OFFSET: ae_off_reg <= reg_wdata[AW-1:0];
        dcfs_pkg::OFS_AF_OFFSET: af_off_reg <= reg_wdata[AW-1:0];
        dcfs_pkg::OFS_IRQ_MASK: irq_mask_reg <= reg_wdata[dcfs_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Sticky events, set wins over clear
  assign irq_set[dcfs_pkg::IRQ_OVERRUN] = wr_edge & wr_en & ~wr_acc;
  assign irq_set[dcfs_pkg::IRQ_UNDERRUN] = rd_edge & rd_en & ~rd_acc;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      irq_stat_reg <= '0;
    end else if (reg_wr && reg_addr == dcfs_pkg::OFS_IRQ_STAT) begin
      irq_stat_reg <= (irq_stat_reg & ~reg_wdata[dcfs_pkg::IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_set;
    end
  end
  assign irq = |(irq_stat_reg & irq_mask_reg);

  // Read data, one cycle after strobe
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        dcfs_pkg::OFS_CONFIG: reg_rdata <= 32'(config_reg);
        dcfs_pkg::OFS_AE_OFFSET: reg_rdata <= 32'(ae_off_reg);
        dcfs_pkg::OFS_AF_OFFSET: reg_rdata <= 32'(af_off_reg);
        dcfs_pkg::OFS_STATUS: begin
          reg_rdata <= '0;
          reg_rdata[dcfs_pkg::ST_COUNT_LO +: PW] <= cnt_reg;
          reg_rdata[dcfs_pkg::ST_FLAGS_LO +: 5] <= {half_full_flag_n, almost_empty_flag_n,
            almost_full_flag_n, empty_flag_n, full_flag_n};
        end
        dcfs_pkg::OFS_IRQ_STAT: reg_rdata <= 32'(irq_stat_reg);
        dcfs_pkg::OFS_IRQ_MASK: reg_rdata <= 32'(irq_mask_reg);
        default: reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  AST_FULL_WRITE_EDGE: assert property ($changed(full_flag_n) |-> $past(wr_edge))
    else $error("full flag moved without a write edge");
  AST_EMPTY_READ_EDGE: assert property ($changed(empty_flag_n) |-> $past(rd_edge))
    else $error("empty flag moved without a read edge");
  AST_NO_WRITE_FULL: assert property (wr_edge && !full_flag_n |=> $stable(wr_ptr_reg))
    else $error("write taken while full");
  AST_NO_READ_EMPTY: assert property (rd_edge && !empty_flag_n |=> $stable(rd_ptr_reg))
    else $error("read taken while empty");
  AST_FULL_SKEW: assert property (rd_acc && !wr_edge ##1 (!wr_edge)[*2] ##1 wr_edge && !wr_en
      |=> full_flag_n)
    else $error("full flag missed a read after skew");
  AST_EMPTY_SKEW: assert property (wr_acc && !rd_edge ##1 (!rd_edge)[*2] ##1 rd_edge && !rd_en
      |=> empty_flag_n)
    else $error("empty flag missed a write after skew");
  AST_OFFSET_DEFAULT: assert property ($rose(rstn) |-> ae_off_reg == OFFSET_RESET
      && af_off_reg == OFFSET_RESET)
    else $error("offset default wrong");
  AST_HF_ASYNC: assert property (hf_mode == dcfs_pkg::HF_ASYNC
      |=> half_full_flag_n == !(cnt_reg > HALF_P))
    else $error("half-full disagrees with count");
  AST_AE_ASYNC: assert property (!config_reg[dcfs_pkg::CFG_AE_SYNC] && $stable(ae_off_reg)
      |=> almost_empty_flag_n == !(cnt_reg <= PW'($past(ae_off_reg))))
    else $error("almost-empty disagrees with count");
  AST_STAGES: assert property (rd_acc |=> rd_ptr_s1 != rd_ptr_reg)
    else $error("opposite pointer bypassed a stage");

  CVR_FULL: cover property ($fell(full_flag_n));
  CVR_EMPTY_LEAVE: cover property ($rose(empty_flag_n));
  CVR_OVERRUN: cover property (irq_set[dcfs_pkg::IRQ_OVERRUN]);
  CVR_HF_WRITE_SIDE: cover property (hf_mode[1] && $fell(half_full_flag_n));
endmodule : dcfs_fifo_flags
`default_nettype wire

// ==== dcfs_port_model.sv ====
// Model of one port subsystem: makes its port clock and enable.
// Assumes clk_sys as reference; edges every four or eight cycles.
`default_nettype none
module dcfs_port_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Bench control
  input wire logic run,
  input wire logic want,
  input wire logic obey,
  input wire logic slow,
  // Own flag, active low
  input wire logic flag_n,
  // Port pins
  output logic pclk,
  output logic en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] ph_reg;
  logic tick;
  assign tick = run && (slow ? ph_reg == 3'h0 : ph_reg[1:0] == 2'h0);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ph_reg <= 3'h0;
      pclk <= 1'b0;
      en <= 1'b0;
    end else begin
      ph_reg <= ph_reg + 3'h1;
      pclk <= tick;
      en <= tick && want && (!obey || flag_n);
    end
  end
endmodule // dcfs_port_model
`default_nettype wire

// ==== tb_dual_clock_fifo_flag_sync.sv ====
// Bench for the FIFO flag block: fills, drains, registers, interrupts.
// Assumes dcfs_port_model drives both ports.
`default_nettype none
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module tb_dual_clock_fifo_flag_sync;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEPTH = dcfs_pkg::DEPTH_SMALL;
  localparam int N_PT = 11;
  localparam int PTS [N_PT] = '{63, 64, 200, 201, 256, 257, 448, 449, 501, 502, 512};
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic wr_clk, wr_en, rd_clk, rd_en, irq;
  logic [dcfs_pkg::DATA_W-1:0] wr_data = '0, rd_data, dexp;
  logic full_flag_n, empty_flag_n, almost_full_flag_n, almost_empty_flag_n, half_full_flag_n;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [1:0] run = 2'b00, want = 2'b00, obey = 2'b11;
  logic [15:0] lfsr_reg = 16'hB09C;
  logic wr_d = 1'b0, rd_d = 1'b0, rp = 1'b0, dp = 1'b0;
  logic [dcfs_pkg::DATA_W-1:0] dq[$];
  logic [31:0] rq[$];
  int cnt = 0, ae_off = 63, af_off = 63, error_cnt = 0, checks = 0;
  int rises [2] = '{0, 0};
  always #4 clk_sys = ~clk_sys;
  dcfs_port_model wr_u (.clk_sys(clk_sys), .rstn(rstn), .run(run[0]), .want(want[0]),
    .obey(obey[0]), .slow(1'b0), .flag_n(full_flag_n), .pclk(wr_clk), .en(wr_en));
  dcfs_port_model rd_u (.clk_sys(clk_sys), .rstn(rstn), .run(run[1]), .want(want[1]),
    .obey(obey[1]), .slow(1'b1), .flag_n(empty_flag_n), .pclk(rd_clk), .en(rd_en));
  dcfs_fifo_flags #(.DEPTH(DEPTH)) dut_u (.clk_sys(clk_sys), .rstn(rstn), .wr_clk(wr_clk),
    .wr_en(wr_en), .wr_data(wr_data), .rd_clk(rd_clk), .rd_en(rd_en), .rd_data(rd_data),
    .full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n),
    .almost_full_flag_n(almost_full_flag_n), .almost_empty_flag_n(almost_empty_flag_n),
    .half_full_flag_n(half_full_flag_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Watcher: notes transfers, compares results against the oldest note
  always @(posedge clk_sys) begin
    if (rp && rq.size() > 0) `CHK(reg_rdata, rq.pop_front())
    if (dp) `CHK(rd_data, dexp)
    rp = reg_rd;
    dp = 1'b0;
    if (wr_clk && !wr_d) rises[0]++;
    if (rd_clk && !rd_d) rises[1]++;
    if (wr_clk && !wr_d && wr_en && cnt < DEPTH) begin
      dq.push_back(wr_data);
      cnt++;
      lfsr_reg = lfsr_next(lfsr_reg);
      wr_data <= {lfsr_reg[1:0], lfsr_reg};
    end
    if (rd_clk && !rd_d && rd_en && cnt > 0) begin
      dexp = dq.pop_front();
      dp = 1'b1;
      cnt--;
    end
    wr_d = wr_clk;
    rd_d = rd_clk;
  end
  task automatic conclude();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic port(input int s, input bit w, input bit ob, input int n);
    int target;
    target = rises[s] + n;
    @(posedge clk_sys);
    want[s] <= w;
    obey[s] <= ob;
    run[s] <= 1'b1;
    for (int i = 0; i < 200 * n + 50 && rises[s] < target; i++) @(negedge clk_sys);
    if (rises[s] < target) begin
      error_cnt++;
      $display("ERROR %0t: port stalled", $time);
      conclude();
    end
    @(posedge clk_sys);
    run[s] <= 1'b0;
    want[s] <= 1'b0;
    repeat (10) @(posedge clk_sys);
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    rq.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask
  task automatic chk_point();
    logic [4:0] f;
    logic [4:0] g;
    f = {cnt <= DEPTH / 2, cnt > ae_off, DEPTH - cnt > af_off, cnt > 0, cnt < DEPTH};
    g = {half_full_flag_n, almost_empty_flag_n, almost_full_flag_n, empty_flag_n, full_flag_n};
    `CHK(g, f)
    reg_read(dcfs_pkg::OFS_STATUS, {11'h0, f, 16'(cnt)});
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    reg_read(dcfs_pkg::OFS_AE_OFFSET, 32'(DEPTH / 8 - 1));
    reg_read(dcfs_pkg::OFS_AF_OFFSET, 32'(DEPTH / 8 - 1));
    reg_read(dcfs_pkg::OFS_CONFIG, 32'h0);
    reg_read(8'h20, 32'h0);
    chk_point();
    for (int i = 0; i < 16; i++) begin
      reg_write(dcfs_pkg::OFS_CONFIG, 32'(i));
      reg_read(dcfs_pkg::OFS_CONFIG, 32'(i));
    end
    reg_write(dcfs_pkg::OFS_CONFIG, 32'h0);
    reg_write(dcfs_pkg::OFS_IRQ_MASK, 32'h3);
    for (int i = 0; i < N_PT; i++) begin
      port(0, 1'b1, 1'b1, PTS[i] - cnt);
      if (i == 0) `CHK(empty_flag_n, 1'b0)
      port(1, 1'b0, 1'b1, 2);
      chk_point();
    end
    port(0, 1'b1, 1'b0, 1);
    chk_point();
    `CHK(irq, 1'b1)
    reg_read(dcfs_pkg::OFS_IRQ_STAT, 32'h1);
    reg_write(dcfs_pkg::OFS_IRQ_STAT, 32'h1);
    reg_read(dcfs_pkg::OFS_IRQ_STAT, 32'h0);
    `CHK(irq, 1'b0)
    reg_write(dcfs_pkg::OFS_AF_OFFSET, 32'hA);
    reg_write(dcfs_pkg::OFS_AE_OFFSET, 32'hC8);
    af_off = 10;
    ae_off = 200;
    reg_read(dcfs_pkg::OFS_AE_OFFSET, 32'hC8);
    for (int i = N_PT - 2; i >= 0; i--) begin
      port(1, 1'b1, 1'b1, cnt - PTS[i]);
      if (i == N_PT - 2) `CHK(full_flag_n, 1'b0)
      port(0, 1'b0, 1'b1, 2);
      chk_point();
    end
    port(1, 1'b1, 1'b1, cnt);
    port(0, 1'b0, 1'b1, 2);
    chk_point();
    reg_write(dcfs_pkg::OFS_CONFIG, 32'hB);
    port(0, 1'b1, 1'b1, 300);
    port(1, 1'b0, 1'b1, 2);
    chk_point();
    reg_write(dcfs_pkg::OFS_CONFIG, 32'hF);
    port(1, 1'b1, 1'b1, cnt);
    port(0, 1'b0, 1'b1, 2);
    chk_point();
    port(1, 1'b1, 1'b0, 1);
    reg_read(dcfs_pkg::OFS_IRQ_STAT, 32'h2);
    `CHK(irq, 1'b1)
    repeat (3) @(posedge clk_sys);
    conclude();
  end
endmodule // tb_dual_clock_fifo_flag_sync
`default_nettype wire
